// ---- design/pief_pkg.sv ----
// Package: offsets, field positions and reset values of the peripheral irq block
package pief_pkg;
  // Register byte addresses
  localparam logic [7:0] PIEF_FLAGS_OFF = 8'h0C;
  localparam logic [7:0] PIEF_ENABLES_OFF = 8'h8C;
  localparam logic [7:0] PIEF_CORE_CTRL_OFF = 8'h10;
  // Flag and enable bit positions
  localparam int PIEF_BIT_PARALLEL = 7;
  localparam int PIEF_BIT_CONVERTER = 6;
  localparam int PIEF_BIT_RX = 5;
  localparam int PIEF_BIT_TX = 4;
  localparam int PIEF_BIT_SYNC = 3;
  localparam int PIEF_BIT_CAPCMP = 2;
  localparam int PIEF_BIT_TMR2 = 1;
  localparam int PIEF_BIT_TMR1 = 0;
  // Core control bit positions
  localparam int PIEF_BIT_GLOBAL_EN = 7;
  localparam int PIEF_BIT_PERIPH_EN = 6;
  // Reset values
  localparam logic [7:0] PIEF_FLAGS_RST = 8'h00;
  localparam logic [7:0] PIEF_ENABLES_RST = 8'h00;
  localparam logic [7:0] PIEF_CTRL_RST = 8'h00;
  // Flags that follow buffer state and ignore writes
  localparam logic [7:0] PIEF_LEVEL_MASK = 8'h30;
  // AHB encodings
  localparam logic [1:0] PIEF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PIEF_HTRANS_SEQ = 2'h3;

  // Peripheral event inputs grouped
  typedef struct packed {
    logic [7:0] pulse; // One-cycle events, rx/tx positions unused
    logic rx_full;     // Receive buffer holds data
    logic tx_empty;    // Transmit buffer is empty
  } pief_events_t;
endpackage

// ---- design/pief_irq.sv ----
// Peripheral interrupt enable and flag logic with AHB-Lite register access
// What this block does
// - Enable register at 0x8C, read/write, eight enables, zero at reset.
// - A set enable bit lets its source request, a clear bit blocks it.
// - No peripheral interrupt leaves while the master enable is clear.
// - Flag register at 0x0C, same order, bits 5 and 4 read-only.
// - An event sets its flag whatever its enable and the global enable.
// - Receive and transmit flags follow buffer state, not writes.
// - Event flags stay set until software writes them to zero.
`timescale 1ns/1ps
`default_nettype none
module pief_irq
  import pief_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pief_events_t events,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] enables_reg, enables_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic irq_reg, irq_next;
  logic access;
  logic [7:0] wbyte;
  logic [7:0] ev_set;

  assign access = hsel && hready && htrans[1];
  assign wbyte = hwdata[7:0];

  // Sticky events; rx/tx positions come from buffer levels instead
  assign ev_set = events.pulse & ~PIEF_LEVEL_MASK;

  // Address decode and read data; reads answer with zero wait states
  always_comb begin
    wr_pend_next = access && hwrite;
    wr_addr_next = access ? haddr[7:0] : wr_addr_reg;
    hrdata_next = hrdata_reg;
    if (access && !hwrite) begin
      unique case (haddr[7:0])
        PIEF_FLAGS_OFF: hrdata_next = {24'h00_0000, flags_reg};
        PIEF_ENABLES_OFF: hrdata_next = {24'h00_0000, enables_reg};
        PIEF_CORE_CTRL_OFF: hrdata_next = {24'h00_0000, ctrl_reg};
        default: hrdata_next = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    flags_next = flags_reg;
    enables_next = enables_reg;
    ctrl_next = ctrl_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        PIEF_FLAGS_OFF: flags_next = wbyte;
        PIEF_ENABLES_OFF: enables_next = wbyte;
        PIEF_CORE_CTRL_OFF: ctrl_next = wbyte;
        default: ;
      endcase
    end
    // Set wins over a clearing write so no event is lost
    flags_next = flags_next | ev_set;
    // Buffer-state flags overwrite whatever was written
    flags_next[PIEF_BIT_RX] = events.rx_full;
    flags_next[PIEF_BIT_TX] = events.tx_empty;
  end

  // Request uses registered state; one cycle after flag or enable change
  always_comb begin
    irq_next = (|(flags_reg & enables_reg))
      && ctrl_reg[PIEF_BIT_PERIPH_EN]
      && ctrl_reg[PIEF_BIT_GLOBAL_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      flags_reg <= PIEF_FLAGS_RST;
      enables_reg <= PIEF_ENABLES_RST;
      ctrl_reg <= PIEF_CTRL_RST;
      irq_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      flags_reg <= flags_next;
      enables_reg <= enables_next;
      ctrl_reg <= ctrl_next;
      irq_reg <= irq_next;
    end
  end

  // Never stalls and never errors, so both are constant flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_master_gate: assert property (
    !ctrl_reg[PIEF_BIT_PERIPH_EN] |=> !irq)
    else $error("irq raised with master enable clear");
  chk_enable_block: assert property (
    (flags_reg & enables_reg) == 8'h00 |=> !irq)
    else $error("irq raised with no enabled flag");
  chk_irq_request: assert property (
    (|(flags_reg & enables_reg)) && ctrl_reg[PIEF_BIT_PERIPH_EN]
    && ctrl_reg[PIEF_BIT_GLOBAL_EN] |=> irq)
    else $error("irq missing when enabled flag set");
  chk_event_sets: assert property (
    events.pulse[PIEF_BIT_TMR1] |=> flags_reg[PIEF_BIT_TMR1])
    else $error("timer one event did not set flag");
  chk_flag_sticky: assert property (
    flags_reg[PIEF_BIT_CONVERTER] && !wr_pend_reg
    |=> flags_reg[PIEF_BIT_CONVERTER])
    else $error("converter flag cleared without write");
  chk_rx_follows: assert property (
    ##1 flags_reg[PIEF_BIT_RX] == $past(events.rx_full))
    else $error("receive flag not following buffer");
  chk_tx_follows: assert property (
    ##1 flags_reg[PIEF_BIT_TX] == $past(events.tx_empty))
    else $error("transmit flag not following buffer");
  chk_enable_write: assert property (
    wr_pend_reg && wr_addr_reg == PIEF_ENABLES_OFF
    |=> enables_reg == $past(wbyte))
    else $error("enable write not stored");
  chk_read_enables: assert property (
    access && !hwrite && haddr[7:0] == PIEF_ENABLES_OFF
    && !wr_pend_reg |=> hrdata[7:0] == $past(enables_reg))
    else $error("enable read wrong");

  // Writes land and reads return the stored byte
  chk_ctrl_write: assert property (
    wr_pend_reg && wr_addr_reg == PIEF_CORE_CTRL_OFF
    |=> ctrl_reg == $past(wbyte))
    else $error("control write not stored");
  chk_read_flags: assert property (
    access && !hwrite && haddr[7:0] == PIEF_FLAGS_OFF
    |=> hrdata[7:0] == $past(flags_reg))
    else $error("flag read wrong");
  chk_read_upper: assert property (
    hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // Slave never stalls, so the master must never see a wait or error
  chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  // Clearing write against a same-cycle event; losing it would drop an irq
  chk_set_wins: assert property (
    wr_pend_reg && wr_addr_reg == PIEF_FLAGS_OFF
    && ev_set[PIEF_BIT_CAPCMP] |=> flags_reg[PIEF_BIT_CAPCMP])
    else $error("clearing write swallowed an event");
  chk_flag_clear: assert property (
    wr_pend_reg && wr_addr_reg == PIEF_FLAGS_OFF
    && !wbyte[PIEF_BIT_TMR2] && !ev_set[PIEF_BIT_TMR2]
    |=> !flags_reg[PIEF_BIT_TMR2])
    else $error("timer two flag not cleared by write");
  chk_level_write: assert property (
    wr_pend_reg && wr_addr_reg == PIEF_FLAGS_OFF
    |=> flags_reg[PIEF_BIT_RX] == $past(events.rx_full))
    else $error("write reached the receive flag");
  chk_enables_hold: assert property (
    !(wr_pend_reg && wr_addr_reg == PIEF_ENABLES_OFF)
    |=> $stable(enables_reg))
    else $error("enables changed without a write");
  chk_global_gate: assert property (
    !ctrl_reg[PIEF_BIT_GLOBAL_EN] |=> !irq)
    else $error("irq raised with global enable clear");

  // One event check per sticky lane; rx and tx lanes follow levels
  for (genvar i = 0; i < 8; i++) begin : g_lane
    if (!PIEF_LEVEL_MASK[i]) begin : g_sticky
      chk_event_lane: assert property (
        events.pulse[i] |=> flags_reg[i])
        else $error("event did not set its flag");
    end
  end

  // Main scenarios worth seeing at least once

  cov_irq_rise: cover property (!irq ##1 irq);
  cov_flag_clear: cover property (flags_reg[PIEF_BIT_TMR2]
    ##1 !flags_reg[PIEF_BIT_TMR2]);
  cov_set_vs_clear: cover property (wr_pend_reg
    && wr_addr_reg == PIEF_FLAGS_OFF && ev_set != 8'h00);
  cov_parallel_irq: cover property (enables_reg[PIEF_BIT_PARALLEL] && irq);
endmodule // pief_irq
`default_nettype wire

// ---- verification/pief_peer.sv ----
// Peripheral event source model facing the irq block
`timescale 1ns/1ps
`default_nettype none
module pief_peer
  import pief_pkg::*;
(
  input wire logic hclk,
  input wire logic [7:0] fire,
  input wire logic rx_lvl,
  input wire logic tx_lvl,
  output pief_events_t events
);
  // Registered like a real peripheral; rx/tx pulse lanes stay quiet
  always_ff @(posedge hclk) begin
    events.pulse <= fire & 8'hCF;
    events.rx_full <= rx_lvl;
    events.tx_empty <= tx_lvl;
  end
endmodule // pief_peer
`default_nettype wire

// ---- verification/test_pief_irq.sv ----
// Self-checking bench for the peripheral irq block over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module test_pief_irq
  import pief_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, rx, tx;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fire;
  logic [31:0] haddr, hwdata, hrdata;
  pief_events_t ev;
  int err_count, num_checks;
  pief_peer peer (.hclk(hclk), .fire(fire), .rx_lvl(rx), .tx_lvl(tx),
    .events(ev));
  pief_irq uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .events(ev), .irq(irq));
  task automatic summarize;
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait so a stuck slave ends the run
  task automatic edge_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= PIEF_HTRANS_NONSEQ;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    edge_rdy();
    q = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, {24'h00_0000, e}, q);
  endtask
  // Settle, sample off the edge, then realign to a rising edge
  task automatic ck_irq(input logic e);
    repeat (4) @(posedge hclk);
    #1 chk("irq", 32'(e), 32'(irq));
    @(posedge hclk);
  endtask
  task automatic pulse(input logic [7:0] m);
    fire <= m;
    @(posedge hclk);
    fire <= 8'h00;
    repeat (3) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, rx, tx} = '0;
    {haddr, hwdata, htrans, fire, err_count, num_checks} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(PIEF_FLAGS_OFF, 8'h00, "flags");
    rd(PIEF_ENABLES_OFF, 8'h00, "enables");
    wr(PIEF_ENABLES_OFF, 8'h5A); // Parallel port enable left clear
    rd(PIEF_ENABLES_OFF, 8'h5A, "enables");
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00, "unmapped");
    // Events with all enables off still raise and keep flags
    wr(PIEF_ENABLES_OFF, 8'h00);
    rx <= 1'b1;
    tx <= 1'b1;
    pulse(8'hFF);
    rd(PIEF_FLAGS_OFF, 8'hFF, "flags");
    wr(PIEF_CORE_CTRL_OFF, 8'hC0);
    rd(PIEF_CORE_CTRL_OFF, 8'hC0, "control");
    ck_irq(1'b0);
    wr(PIEF_FLAGS_OFF, 8'h00);
    rd(PIEF_FLAGS_OFF, 8'h30, "flags");
    rx <= 1'b0;
    tx <= 1'b0;
    // Event landing in the data phase of a clearing write must survive
    fork
      wr(PIEF_FLAGS_OFF, 8'h00);
      pulse(8'h04);
    join
    rd(PIEF_FLAGS_OFF, 8'h04, "flags");
    wr(PIEF_FLAGS_OFF, 8'h00); // Clear before enabling
    // Each source alone, then gated by master and global enables
    for (int b = 0; b < 8; b++) begin
      wr(PIEF_ENABLES_OFF, 8'(1 << b));
      rx <= (b == 5);
      tx <= (b == 4);
      if (b < 4 || b > 5) pulse(8'(1 << b));
      ck_irq(1'b1);
      wr(PIEF_CORE_CTRL_OFF, 8'h80);
      ck_irq(1'b0);
      wr(PIEF_CORE_CTRL_OFF, 8'h40);
      ck_irq(1'b0);
      wr(PIEF_CORE_CTRL_OFF, 8'hC0);
      rx <= 1'b0;
      tx <= 1'b0;
      wr(PIEF_FLAGS_OFF, 8'h00);
      ck_irq(1'b0);
    end
    summarize();
  end
endmodule // test_pief_irq
`default_nettype wire
